/* File: common/memc_pkg.sv */
package memc_pkg;
  // bus data width and register word offsets
  localparam int REG_W = 16;
  localparam int DB_W = 4;
  localparam int PS_MAX = 5;
  localparam logic [5:0] OFS_T0CNT = 6'h00;
  localparam logic [5:0] OFS_T0PR = 6'h01;
  localparam logic [5:0] OFS_T0CON = 6'h02;
  localparam logic [5:0] OFS_T1CNT = 6'h03;
  localparam logic [5:0] OFS_T1PR = 6'h04;
  localparam logic [5:0] OFS_T1CON = 6'h05;
  localparam logic [5:0] OFS_COMCON = 6'h06;
  localparam logic [5:0] OFS_CMP0 = 6'h07;
  localparam logic [5:0] OFS_DEADBAND_CONTROL_REG = 6'h0a;
  localparam logic [5:0] OFS_CAPCON = 6'h0b;
  localparam logic [5:0] OFS_CAPTURE_FIFO_STATUS_REG = 6'h0c;
  localparam logic [5:0] OFS_CAPTOP0 = 6'h0d;
  localparam logic [5:0] OFS_CAPBOT0 = 6'h10;
  localparam logic [5:0] OFS_IFR = 6'h13;
  localparam logic [5:0] OFS_IMR = 6'h14;
  // timer control fields
  localparam int TC_MODE_LSB = 11;
  localparam int TC_EN = 6;
  localparam int TC_SRC_LSB = 4;
  localparam logic [15:0] TCON_MASK = 16'h1870;
  // compare control fields
  localparam int CC_EN = 15;
  localparam int CC_PIN = 8;
  localparam logic [15:0] COMCON_MASK = 16'h8000;
  // dead-band control fields
  localparam int DB_PER_LSB = 8;
  localparam int DB_EN_LSB = 5;
  localparam int DB_PS_LSB = 2;
  localparam logic [15:0] DEADBAND_CONTROL_REG_MASK = 16'h0ffc;
  // capture control and fifo status fields
  localparam int CP_ADC = 15;
  localparam int CP_EN_LSB = 12;
  localparam int CP_TB_LSB = 9;
  localparam logic [15:0] CAPCON_MASK = 16'hfe3f;
  localparam int CF_LSB = 8;
  localparam logic [15:0] CAPTURE_FIFO_STATUS_REG_MASK = 16'h3f00;
  // interrupt flag positions
  localparam int IF_FAULT = 0;
  localparam int IF_TPER = 1;
  localparam int IF_CAP = 3;
  localparam int IF_N = 6;
  localparam logic [5:0] IMR_RST = 6'h01;
  // timer constants
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam int QEP_TMR = 1;

  // counting modes, two-bit field
  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_CUD = 2'b01,
    MODE_CUP = 2'b10,
    MODE_DIR = 2'b11
  } memc_mode_t;

  // timer clock sources
  typedef enum logic [1:0] {
    SRC_INT = 2'b00,
    SRC_EXT = 2'b01,
    SRC_RSV = 2'b10,
    SRC_QEP = 2'b11
  } memc_src_t;

  // decoded timer control
  typedef struct packed {
    memc_mode_t mode;
    logic en;
    memc_src_t src;
  } memc_tcfg_t;
endpackage

/* File: rtl/memc_core.sv */
// Local design decisions: the Avalon-MM register port and the register offsets.
module memc_core
  import memc_pkg::*;
#(
  parameter int CW = 16,
  parameter int DBW = 4
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [15:0] avs_writedata,
  output logic [15:0] avs_readdata,
  output logic avs_waitrequest,
  // timer pins
  input wire logic timer_clock_in,
  input wire logic timer_dir_in,
  // capture and quadrature inputs
  input wire logic [2:0] cap_in,
  // power stage
  input wire logic power_stage_fault_input_n,
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_oe,
  // system outputs
  output logic adc_soc,
  output logic irq
);

  // refuse widths the logic cannot serve
  if (CW != REG_W || DBW != DB_W)
  begin : g_bad_width
    $error("memc_core: unsupported width");
  end

  // bus handshake: one wait state on every access
  logic ack_q;
  logic [15:0] rdata_q;
  wire acc = avs_read | avs_write;
  wire wr_en = avs_write & ack_q;
  wire rd_en = avs_read & ack_q;
  assign avs_waitrequest = acc & ~ack_q;
  assign avs_readdata = rdata_q;

  // software registers
  logic [15:0] pr_q [2]; // timer periods
  logic [15:0] tcon_q [2]; // timer controls
  logic [15:0] comcon_q; // compare control
  logic [15:0] cmp_q [3]; // compare values
  logic [15:0] dbt_q; // dead-band control
  logic [15:0] capcon_q; // capture control
  logic [IF_N-1:0] ifr_q; // sticky flags
  logic [IF_N-1:0] imr_q; // flag enables

  // per-unit state exported from generate loops
  logic [15:0] tcnt [2];
  logic [1:0] tper_ev;
  logic [2:0] cap_ev;
  logic [1:0] fcnt [3];
  logic [15:0] ctop [3];
  logic [15:0] cbot [3];
  logic [2:0] raw_cmp;
  logic [5:0] pwm_d;

  // write strobes per register
  wire wr_ifr = wr_en & (avs_address == OFS_IFR);
  wire wr_cf = wr_en & (avs_address == OFS_CAPTURE_FIFO_STATUS_REG);

  // handshake toggles so the second cycle completes
  always_ff @(posedge clock)
  begin
    if (reset)
      ack_q <= 1'b0;
    else
      ack_q <= acc & ~ack_q;
  end

  // one write loads a whole register; reserved bits masked
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pr_q <= '{default: 16'h0000};
      tcon_q <= '{default: 16'h0000};
      cmp_q <= '{default: 16'h0000};
      comcon_q <= 16'h0000;
      dbt_q <= 16'h0000;
      capcon_q <= 16'h0000;
      imr_q <= IMR_RST;
    end
    else if (wr_en)
    begin
      case (avs_address)
        OFS_T0PR: pr_q[0] <= avs_writedata;
        OFS_T1PR: pr_q[1] <= avs_writedata;
        // legacy mode bit and cascade bits stay zero
        OFS_T0CON: tcon_q[0] <= avs_writedata & TCON_MASK;
        OFS_T1CON: tcon_q[1] <= avs_writedata & TCON_MASK;
        // single write, no second arming write
        OFS_COMCON: comcon_q <= avs_writedata & COMCON_MASK;
        OFS_CMP0: cmp_q[0] <= avs_writedata;
        OFS_CMP0 + 6'h01: cmp_q[1] <= avs_writedata;
        OFS_CMP0 + 6'h02: cmp_q[2] <= avs_writedata;
        OFS_DEADBAND_CONTROL_REG: dbt_q <= avs_writedata & DEADBAND_CONTROL_REG_MASK;
        OFS_CAPCON: capcon_q <= avs_writedata & CAPCON_MASK;
        OFS_IMR: imr_q <= avs_writedata[IF_N-1:0];
        // unmapped offsets take no write
        default: imr_q <= imr_q;
      endcase
    end
  end

  // fault pin qualification: two-stage sync then edge
  logic fs1_q, fs2_q, fs3_q;
  wire fault_ev = fs3_q & ~fs2_q;
  wire fault_en = imr_q[IF_FAULT];
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      fs1_q <= 1'b1;
      fs2_q <= 1'b1;
      fs3_q <= 1'b1;
    end
    else
    begin
      fs1_q <= power_stage_fault_input_n;
      fs2_q <= fs1_q;
      fs3_q <= fs2_q;
    end
  end

  // flags: set wins over write-one clear, reads never clear
  wire [IF_N-1:0] set_v = {cap_ev, tper_ev, fault_ev};
  wire [IF_N-1:0] cap_set;
  always_ff @(posedge clock)
  begin
    if (reset)
      ifr_q <= '0;
    else if (wr_ifr)
      ifr_q <= (ifr_q & ~avs_writedata[IF_N-1:0]) | cap_set;
    else
      ifr_q <= ifr_q | cap_set;
  end
  // capture sources only flag when their fifo was non-empty
  assign cap_set = {cap_ev & {fcnt[2] != 2'd0, fcnt[1] != 2'd0,
                    fcnt[0] != 2'd0}, set_v[IF_CAP-1:0]};
  assign irq = |(ifr_q & imr_q);

  // outputs float at once on an enabled fault
  wire hiz = fault_en & (~power_stage_fault_input_n | ifr_q[IF_FAULT]);
  assign pwm_oe = {6{~hiz}};

  // quadrature decoder on capture pins 0 and 1
  logic qa_q, qb_q;
  wire qep_tick = (cap_in[0] ^ qa_q) | (cap_in[1] ^ qb_q);
  wire qep_up = qa_q ^ cap_in[1];
  logic tclk_q;
  wire ext_tick = timer_clock_in & ~tclk_q;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      qa_q <= 1'b0;
      qb_q <= 1'b0;
      tclk_q <= 1'b0;
    end
    else
    begin
      qa_q <= cap_in[0];
      qb_q <= cap_in[1];
      tclk_q <= timer_clock_in;
    end
  end

  // two general-purpose timers
  for (genvar t = 0; t < 2; t++)
  begin : g_tmr
    memc_tcfg_t cfg;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic dir_q; // up when high, for continuous up/down
    logic tick;
    logic want_up;
    wire at_pr = (cnt_q == pr_q[t]);
    wire wr_cnt = wr_en & (avs_address == (t ? OFS_T1CNT : OFS_T0CNT));
    // unpack mode, enable and clock source from the control word
    assign cfg = memc_tcfg_t'({tcon_q[t][TC_MODE_LSB +: 2],
      tcon_q[t][TC_EN], tcon_q[t][TC_SRC_LSB +: 2]});
    // only the second timer accepts decoder clocking
    assign tick = cfg.en & (cfg.src == SRC_INT ? 1'b1 :
      cfg.src == SRC_EXT ? ext_tick :
      cfg.src == SRC_QEP ? (t == QEP_TMR) & qep_tick : 1'b0);
    assign want_up = (cfg.src == SRC_QEP) ? qep_up : timer_dir_in;
    // next count per mode
    always_comb
    begin
      cnt_d = cnt_q;
      case (cfg.mode)
        MODE_CUP: cnt_d = at_pr ? CNT_ZERO : cnt_q + 16'h0001;
        // turn at the period and at zero without overshooting
        MODE_CUD: cnt_d = ((dir_q & ~at_pr) | (cnt_q == CNT_ZERO))
          ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        // reverse at an end point instead of holding
        MODE_DIR:
        begin
          if (want_up)
            cnt_d = (at_pr | cnt_q == CNT_TOP) ? cnt_q - 16'h0001
                                               : cnt_q + 16'h0001;
          else
            cnt_d = (cnt_q == CNT_ZERO) ? cnt_q + 16'h0001
                                        : cnt_q - 16'h0001;
        end
        default: cnt_d = cnt_q;
      endcase
    end
    // counter and continuous up/down direction
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        cnt_q <= 16'h0000;
        dir_q <= 1'b1;
      end
      else if (wr_cnt)
        cnt_q <= avs_writedata;
      else if (tick)
      begin
        cnt_q <= cnt_d;
        if (at_pr)
          dir_q <= 1'b0;
        else if (cnt_q == CNT_ZERO)
          dir_q <= 1'b1;
      end
    end
    assign tcnt[t] = cnt_q;
    assign tper_ev[t] = tick & at_pr;
  end

  // three capture units with two-deep fifos
  for (genvar c = 0; c < 3; c++)
  begin : g_cap
    logic in_q;
    logic [15:0] top_q, bot_q;
    logic [1:0] n_q;
    logic [1:0] edge_sel;
    wire rise = cap_in[c] & ~in_q;
    wire fall = ~cap_in[c] & in_q;
    wire pop = rd_en & (avs_address == OFS_CAPTOP0 + 6'(c));
    // time base from either timer
    wire [15:0] tb = capcon_q[CP_TB_LSB + c] ? tcnt[1] : tcnt[0];
    assign edge_sel = capcon_q[2*c +: 2];
    assign cap_ev[c] = capcon_q[CP_EN_LSB + c] &
      ((edge_sel[0] & rise) | (edge_sel[1] & fall));
    // fifo: capture pushes, top read pops, status writable
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        in_q <= 1'b0;
        top_q <= 16'h0000;
        bot_q <= 16'h0000;
        n_q <= 2'd0;
      end
      else
      begin
        in_q <= cap_in[c];
        if (cap_ev[c])
        begin
          case (n_q)
            2'd0:
            begin
              top_q <= tb;
              n_q <= 2'd1;
            end
            2'd1:
            begin
              bot_q <= tb;
              n_q <= 2'd2;
            end
            // full: oldest dropped
            default:
            begin
              top_q <= bot_q;
              bot_q <= tb;
              n_q <= 2'd2;
            end
          endcase
        end
        else if (wr_cf)
          n_q <= avs_writedata[CF_LSB + 2*c +: 2];
        else if (pop && n_q != 2'd0)
        begin
          top_q <= bot_q;
          n_q <= n_q - 2'd1;
        end
      end
    end
    assign fcnt[c] = n_q;
    assign ctop[c] = top_q;
    assign cbot[c] = bot_q;
  end

  // conversion start on each event of the third capture unit, when enabled
  always_ff @(posedge clock)
  begin
    if (reset)
      adc_soc <= 1'b0;
    else
      adc_soc <= cap_ev[2] & capcon_q[CP_ADC];
  end

  // dead-band prescaler: divide by 2^sel, up to 32
  logic [PS_MAX-1:0] pre_q;
  wire [2:0] ps_sel = dbt_q[DB_PS_LSB +: 3];
  wire [2:0] ps_use = (ps_sel > 3'(PS_MAX)) ? 3'(PS_MAX) : ps_sel;
  wire [PS_MAX-1:0] ps_mask = PS_MAX'((6'h01 << ps_use) - 6'h01);
  wire db_tick = ((pre_q | ~ps_mask) == '1);
  always_ff @(posedge clock)
  begin
    if (reset)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  // compare units, pwm only, with 4-bit dead band
  for (genvar u = 0; u < 3; u++)
  begin : g_pwm
    logic raw_q;
    logic [DB_W-1:0] db_q;
    wire raw_d = comcon_q[CC_EN] & (tcnt[0] < cmp_q[u]);
    wire db_on = dbt_q[DB_EN_LSB + u];
    wire db_done = ~db_on | (db_q == '0);
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        raw_q <= 1'b0;
        db_q <= '0;
      end
      else
      begin
        raw_q <= raw_d;
        if (raw_d != raw_q)
          db_q <= dbt_q[DB_PER_LSB +: DB_W];
        else if (db_tick && db_q != '0)
          db_q <= db_q - 1'b1;
      end
    end
    assign raw_cmp[u] = raw_q;
    assign pwm_d[2*u] = raw_q & db_done & (raw_d == raw_q);
    assign pwm_d[2*u+1] = ~raw_q & comcon_q[CC_EN] & db_done &
      (raw_d == raw_q);
  end

  // pwm data from flops
  always_ff @(posedge clock)
  begin
    if (reset)
      pwm_out <= 6'h00;
    else
      pwm_out <= pwm_d;
  end

  // read mux; anything unmapped reads zero
  logic [15:0] rmux;
  always_comb
  begin
    case (avs_address)
      OFS_T0CNT: rmux = tcnt[0];
      OFS_T0PR: rmux = pr_q[0];
      OFS_T0CON: rmux = tcon_q[0];
      OFS_T1CNT: rmux = tcnt[1];
      OFS_T1PR: rmux = pr_q[1];
      OFS_T1CON: rmux = tcon_q[1];
      OFS_COMCON: rmux = comcon_q | (16'(fs2_q) << CC_PIN);
      OFS_CMP0: rmux = cmp_q[0];
      OFS_CMP0 + 6'h01: rmux = cmp_q[1];
      OFS_CMP0 + 6'h02: rmux = cmp_q[2];
      OFS_DEADBAND_CONTROL_REG: rmux = dbt_q;
      OFS_CAPCON: rmux = capcon_q;
      // low six bits read zero
      OFS_CAPTURE_FIFO_STATUS_REG: rmux = 16'({fcnt[2], fcnt[1], fcnt[0]}) << CF_LSB;
      OFS_CAPTOP0: rmux = ctop[0];
      OFS_CAPTOP0 + 6'h01: rmux = ctop[1];
      OFS_CAPTOP0 + 6'h02: rmux = ctop[2];
      // second entry readable alone, no pop
      OFS_CAPBOT0: rmux = cbot[0];
      OFS_CAPBOT0 + 6'h01: rmux = cbot[1];
      OFS_CAPBOT0 + 6'h02: rmux = cbot[2];
      OFS_IFR: rmux = 16'(ifr_q);
      OFS_IMR: rmux = 16'(imr_q);
      default: rmux = 16'h0000;
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge clock)
  begin
    if (reset)
      rdata_q <= 16'h0000;
    else if (avs_read & ~ack_q)
      rdata_q <= rmux;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_fault_fall;
    power_stage_fault_input_n ##1 !power_stage_fault_input_n [*3];
  endsequence
  sequence s_edge_db;
    $changed(raw_cmp[0]) && dbt_q[DB_EN_LSB]
      && dbt_q[DB_PER_LSB +: DB_W] != '0;
  endsequence

  a_fault_hiz_now: assert property (
    fault_en && !power_stage_fault_input_n |-> pwm_oe == 6'h00)
    else $error("pwm not floated on fault");
  a_fault_flag_delay: assert property (
    s_fault_fall |=> ifr_q[IF_FAULT])
    else $error("fault flag not set after qualification");
  a_flag_sticky: assert property (
    !wr_ifr |=> (ifr_q & $past(ifr_q)) == $past(ifr_q))
    else $error("flag lost without clear write");
  a_irq_mask_gate: assert property (
    irq |-> (ifr_q & imr_q) != '0 ##0 imr_q != '0)
    else $error("request without enabled flag");
  a_fault_en_reset: assert property (
    $fell(reset) |-> imr_q[IF_FAULT])
    else $error("fault interrupt disabled after reset");
  a_cap_first_quiet: assert property (
    cap_ev[2] && fcnt[2] == 2'd0 && !ifr_q[IF_CAP + 2] && !wr_ifr
    |=> !ifr_q[IF_CAP + 2])
    else $error("capture flag on first entry");
  a_cap_adc_start: assert property (
    cap_ev[2] && capcon_q[CP_ADC] |=> adc_soc)
    else $error("no conversion start");
  a_fifo_low_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == OFS_CAPTURE_FIFO_STATUS_REG
    |-> avs_readdata[5:0] == 6'h00)
    else $error("reserved fifo bits not zero");
  a_dir_reverse_top: assert property (
    g_tmr[1].cfg.mode == MODE_DIR && g_tmr[1].tick && !avs_write
    && g_tmr[1].want_up && (g_tmr[1].at_pr || tcnt[1] == CNT_TOP)
    |=> tcnt[1] == $past(tcnt[1]) - 16'h0001)
    else $error("timer held at end point");
  a_dir_reverse_low: assert property (
    g_tmr[1].cfg.mode == MODE_DIR && g_tmr[1].tick && !avs_write
    && !g_tmr[1].want_up && tcnt[1] == CNT_ZERO
    |=> tcnt[1] == CNT_ZERO + 16'h0001)
    else $error("timer held at zero");
  a_db_gap_low: assert property (
    s_edge_db |=> pwm_out[1:0] == 2'b00)
    else $error("no dead band after edge");

endmodule

/* File: testbench/memc_partner.sv */
// power stage, timer pins and capture sources seen from the block's pins
module memc_partner
(
  // clock and bench commands
  input wire logic clock,
  input wire logic [2:0] cap_req,
  input wire logic fault_req,
  input wire logic dir_req,
  // lines toward the block
  output logic [2:0] cap_in,
  output logic fault_n,
  output logic tclk,
  output logic tdir
);
  timeunit 1ns;
  timeprecision 100ps;
  // pulse state of each capture source
  logic [2:0] cap_q = 3'h0;
  logic [1:0] cnt_q [3] = '{2'h0, 2'h0, 2'h0};

  // fault line is pulled high unless the stage reports a fault
  assign fault_n = ~fault_req;
  // no external clock edges; direction up unless the bench asks down
  assign tclk = 1'b0;
  assign tdir = ~dir_req;
  assign cap_in = cap_q;

  // each capture request becomes a pulse a few cycles wide
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (cap_req[i])
      begin
        cnt_q[i] <= 2'h3;
        cap_q[i] <= 1'b1;
      end
      else if (cnt_q[i] != 2'h0)
        cnt_q[i] <= cnt_q[i] - 2'h1;
      else
        cap_q[i] <= 1'b0;
    end
  end
endmodule

/* File: testbench/memc_core_tb_top.sv */
// self-checking bench for the motion event manager core
module memc_core_tb_top
  import memc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // one register access and the value it should read back
  typedef struct packed {
    logic [5:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } memc_row_t;

  logic clock = 1'b0;
  logic reset = 1'b1;
  // bus master side
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [15:0] avs_writedata = 16'h0000;
  logic [15:0] avs_readdata;
  logic avs_waitrequest;
  // pin side
  logic timer_clock_in, timer_dir_in, fault_n;
  logic [2:0] cap_in;
  logic [2:0] cap_req = 3'h0;
  logic fault_req = 1'b0;
  logic dir_req = 1'b0;
  logic [5:0] pwm_out, pwm_oe;
  logic adc_soc, irq;
  // scoreboard counters and scratch
  int n_errors = 0;
  int checks_done = 0;
  int n;
  logic [15:0] rd, b, t, prev;
  logic saw_down, saw_up;
  // writes, then readbacks masked to the implemented bits
  memc_row_t rows [9] = '{
    '{OFS_T0PR, 16'h1234, 16'h1234}, '{OFS_T0CON, 16'hffff, 16'h1870},
    '{OFS_COMCON, 16'hffff, 16'h8100}, '{OFS_DEADBAND_CONTROL_REG, 16'hffff, 16'h0ffc},
    '{OFS_CAPTURE_FIFO_STATUS_REG, 16'hffff, 16'h3f00}, '{OFS_IMR, 16'hffff, 16'h003f},
    '{OFS_IFR, 16'hffff, 16'h0000}, '{6'h15, 16'hffff, 16'h0000},
    '{6'h3f, 16'hffff, 16'h0000}};

  memc_core uut (
    .clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_clock_in(timer_clock_in),
    .timer_dir_in(timer_dir_in), .cap_in(cap_in),
    .power_stage_fault_input_n(fault_n), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .adc_soc(adc_soc), .irq(irq));

  memc_partner stage (
    .clock(clock), .cap_req(cap_req), .fault_req(fault_req),
    .dir_req(dir_req),
    .cap_in(cap_in), .fault_n(fault_n), .tclk(timer_clock_in),
    .tdir(timer_dir_in));

  // 200 mhz clock
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // compare a register word
  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compare a single pin or flag
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  // one bus access; held until waitrequest is sampled low
  task automatic bus_go(input logic wr, input logic [5:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20)
    begin
      n_errors++;
      summarize();
    end
  endtask

  task automatic bus_write(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus_go(1'b1, a, d, q);
  endtask

  task automatic bus_read(input logic [5:0] a, output logic [15:0] q);
    bus_go(1'b0, a, 16'h0000, q);
  endtask

  // one-cycle request to a capture source
  task automatic cap_pulse(input int u);
    @(posedge clock);
    cap_req[u] <= 1'b1;
    @(posedge clock);
    cap_req[u] <= 1'b0;
  endtask

  // bound on the whole run
  initial
  begin
    repeat (50000) @(posedge clock);
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    // register table: implemented bits, reserved and unmapped places
    for (int i = 0; i < 9; i++)
    begin
      bus_write(rows[i].a, rows[i].d);
      bus_read(rows[i].a, rd);
      chk_word("reg_readback", rows[i].e, rd);
    end
    // mid-run reset brings back the reset state
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    bus_read(OFS_IMR, rd);
    chk_word("imr_reset", 16'h0001, rd);
    bus_read(OFS_IFR, rd);
    chk_word("ifr_reset", 16'h0000, rd);
    bus_read(OFS_CAPTURE_FIFO_STATUS_REG, rd);
    chk_word("capture_fifo_status_reg_reset", 16'h0000, rd);
    bus_read(OFS_COMCON, rd);
    chk_word("comcon_reset", 16'h0100, rd);
    chk_word("oe_reset", 16'h003f, {10'h000, pwm_oe});
    chk_bit("irq_reset", 1'b0, irq);
    // unmasked fault: outputs float at once, flag after qualification
    @(posedge clock);
    fault_req <= 1'b1;
    #1 chk_word("oe_fault", 16'h0000, {10'h000, pwm_oe});
    @(posedge clock);
    #1 chk_bit("irq_early", 1'b0, irq);
    repeat (4) @(posedge clock);
    #1 chk_bit("irq_fault", 1'b1, irq);
    bus_read(OFS_IFR, rd);
    bus_read(OFS_IFR, rd);
    chk_word("ifr_kept", 16'h0001, rd);
    fault_req <= 1'b0;
    repeat (4) @(posedge clock);
    bus_write(OFS_IFR, 16'h0001);
    bus_read(OFS_IFR, rd);
    chk_word("ifr_clear", 16'h0000, rd);
    chk_bit("irq_clear", 1'b0, irq);
    chk_word("oe_back", 16'h003f, {10'h000, pwm_oe});
    // masked fault: flag still set, no float, no request
    bus_write(OFS_IMR, 16'h0000);
    fault_req <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk_word("oe_masked", 16'h003f, {10'h000, pwm_oe});
    chk_bit("irq_masked", 1'b0, irq);
    bus_read(OFS_IFR, rd);
    chk_word("ifr_masked", 16'h0001, rd);
    fault_req <= 1'b0;
    repeat (4) @(posedge clock);
    bus_write(OFS_IFR, 16'h0001);
    // capture unit three on a running timer 0, rising edges
    bus_write(OFS_T0PR, 16'hffff);
    bus_write(OFS_T0CON, 16'h1040);
    bus_write(OFS_CAPCON, 16'hf015);
    cap_pulse(2);
    n = 0;
    repeat (12)
    begin
      @(posedge clock);
      #1 if (adc_soc === 1'b1) n++;
    end
    chk_word("adc_pulses", 16'h0001, 16'(n));
    bus_read(OFS_IFR, rd);
    chk_bit("cap_flag_first", 1'b0, rd[IF_CAP + 2]);
    bus_read(OFS_CAPTURE_FIFO_STATUS_REG, rd);
    chk_word("fifo_one", 16'h1000, rd);
    cap_pulse(2);
    repeat (8) @(posedge clock);
    bus_read(OFS_IFR, rd);
    chk_bit("cap_flag_second", 1'b1, rd[IF_CAP + 2]);
    bus_read(OFS_CAPBOT0 + 6'h02, b);
    bus_read(OFS_CAPTURE_FIFO_STATUS_REG, rd);
    chk_word("fifo_no_pop", 16'h2000, rd);
    bus_read(OFS_CAPTOP0 + 6'h02, t);
    chk_bit("entries_differ", 1'b1, t !== b);
    bus_read(OFS_CAPTURE_FIFO_STATUS_REG, rd);
    chk_word("fifo_pop", 16'h1000, rd);
    bus_write(OFS_IFR, 16'h003f);
    // pwm: unit 0 high below compare, then a dead-band gap on its fall
    bus_write(OFS_CMP0, 16'hffff);
    bus_write(OFS_COMCON, 16'h8000);
    repeat (4) @(posedge clock);
    #1 chk_word("pwm_run", 16'h0029, {10'h000, pwm_out});
    bus_write(OFS_DEADBAND_CONTROL_REG, 16'h0820);
    bus_write(OFS_CMP0, 16'h0000);
    @(posedge clock);
    #1 chk_word("pwm_gap", 16'h0028, {10'h000, pwm_out});
    repeat (20) @(posedge clock);
    #1 chk_word("pwm_low", 16'h002a, {10'h000, pwm_out});
    // directional count with direction up still turns at the period
    bus_write(OFS_T1PR, 16'h0004);
    bus_write(OFS_T1CON, 16'h1840);
    prev = 16'h0000;
    saw_down = 1'b0;
    repeat (12)
    begin
      bus_read(OFS_T1CNT, rd);
      chk_bit("t1cnt_range", 1'b1, rd <= 16'h0004);
      if (rd < prev) saw_down = 1'b1;
      prev = rd;
    end
    chk_bit("t1_reversed", 1'b1, saw_down);
    // direction down: the count turns at zero instead of holding
    dir_req <= 1'b1;
    prev = 16'h0004;
    saw_up = 1'b0;
    repeat (12)
    begin
      bus_read(OFS_T1CNT, rd);
      chk_bit("t1cnt_low", 1'b1, rd <= 16'h0004);
      if (rd > prev) saw_up = 1'b1;
      prev = rd;
    end
    chk_bit("t1_turned", 1'b1, saw_up);
    summarize();
  end
endmodule
